/* inc/adcc_pkg.sv */
// constants, field layouts and carriers of the converter channel control
// assumes a 32-bit AHB-Lite register bus and one pipelined analog core
package adcc_pkg;
  localparam int NCH = 4;
  localparam int CHW = 2;
  localparam int DW = 12;
  localparam int RW = 16;
  localparam int CMPW = 12;

  // register byte offsets; channel pages sit at 0x20 + 8*ch
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMP = 8'h04;
  localparam logic [7:0] OFS_START = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0C;
  localparam logic [2:0] OFS_CH_PAGE = 3'h1;
  localparam int CH_IDX_LSB = 3;
  localparam int CH_RES_BIT = 2;

  // control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_SIGNED = 1;
  localparam int CTRL_RES8 = 2;
  localparam int CTRL_PRESC_LSB = 4;
  localparam int PRESC_W = 3;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0077;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [CMPW-1:0] CMP_RST = 12'h000;
  localparam logic [RW-1:0] RES_RST = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // converter clock is hclk divided by PDIV_MIN << prescale
  localparam int PDIV_W = 10;
  localparam logic [PDIV_W-1:0] PDIV_MIN = 10'h004;

  // latency in converter clocks: base + resolution/2 + gain stage
  localparam logic [3:0] LAT_BASE = 4'h1;
  localparam logic [3:0] LAT_GAIN = 4'h1;
  localparam logic [3:0] RES_BITS12 = 4'hC;
  localparam logic [3:0] RES_BITS8 = 4'h8;
  localparam int LAT_MAX = 8;

  typedef enum logic [1:0] {
    MODE_DIFF, MODE_DIFFGAIN, MODE_SINGLE, MODE_INTERNAL
  } adcc_mode_e;

  typedef enum logic [1:0] {
    CMP_ANY, CMP_ABOVE, CMP_BELOW, CMP_NONE
  } adcc_cmp_e;

  // core positive select: 0..15 pins, then temp, bandgap, dac, vcc/10
  localparam logic [4:0] POS_INT_BASE = 5'h10;
  // core negative select: 0..7 pins, then pad gnd, int gnd, vref/2 - dv
  localparam logic [3:0] NEG_GAIN_BASE = 4'h4;
  localparam logic [3:0] NEG_PADGND = 4'h8;
  localparam logic [3:0] NEG_INTGND = 4'h9;
  localparam logic [3:0] NEG_HALFREF = 4'hA;
  // negative field codes in a channel config
  localparam logic [3:0] CFG_NEG_PINS = 4'h4;
  localparam logic [3:0] CFG_NEG_PADGND = 4'h4;

  // gain code 0..7 selects 1/2x, 1x, 2x, 4x, 8x, 16x, 32x, 64x
  typedef struct packed {
    logic [2:0] evsel;
    logic ev_en;
    logic ie;
    adcc_cmp_e cmpm;
    logic [2:0] gain;
    logic [3:0] negs;
    logic [3:0] poss;
    adcc_mode_e mode;
  } adcc_chcfg_s;
  localparam int CFG_W = 20;
  localparam logic [CFG_W-1:0] CFG_RST = 20'h00000;

  typedef struct packed {
    logic [4:0] pos_sel;
    logic [3:0] neg_sel;
    logic gain_en;
    logic [2:0] gain;
    logic signed_m;
    logic res8;
  } adcc_core_s;
  localparam int CORE_W = 15;
endpackage

/* hw/adcc_slot_track.sv */
// in-flight conversion tracker: one slot per conversion in the pipeline
// assumes issue only ever happens together with tick
`timescale 1ns/10ps
`default_nettype none
module adcc_slot_track
  import adcc_pkg::*;
#(
  parameter int NSLOT = LAT_MAX
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clear,
  input wire logic tick,
  // new conversion
  input wire logic issue,
  input wire logic [CHW-1:0] issue_ch,
  input wire logic [3:0] issue_lat,
  // completion
  output logic done,
  output logic [CHW-1:0] done_ch
);
  logic [NSLOT-1:0] vld_r, vld_nxt;
  logic [CHW-1:0] ch_r [NSLOT];
  logic [CHW-1:0] ch_nxt [NSLOT];
  logic [3:0] cnt_r [NSLOT];
  logic [3:0] cnt_nxt [NSLOT];
  logic placed;

  if (NSLOT < LAT_MAX) begin : g_chk
    $error("adcc_slot_track: NSLOT below the longest latency");
  end

  always_comb begin
    vld_nxt = vld_r;
    ch_nxt = ch_r;
    cnt_nxt = cnt_r;
    done = 1'b0;
    done_ch = '0;
    placed = 1'b0;
    if (tick) begin
      for (int i = 0; i < NSLOT; i++) begin
        if (vld_r[i]) begin
          if (cnt_r[i] == 4'h1) begin
            done = 1'b1;
            done_ch = ch_r[i];
            vld_nxt[i] = 1'b0;
          end else begin
            cnt_nxt[i] = cnt_r[i] - 4'h1;
          end
        end
      end
    end
    if (issue) begin
      for (int i = 0; i < NSLOT; i++) begin
        if (!vld_nxt[i] && !placed) begin
          placed = 1'b1;
          vld_nxt[i] = 1'b1;
          ch_nxt[i] = issue_ch;
          cnt_nxt[i] = issue_lat;
        end
      end
    end
    if (clear) begin
      vld_nxt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vld_r <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        ch_r[i] <= '0;
        cnt_r[i] <= 4'h0;
      end
    end else begin
      vld_r <= vld_nxt;
      ch_r <= ch_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

/* hw/adcc_top.sv */
// four-channel control for a pipelined 12-bit converter core
// assumes an AHB-Lite master, an event system on ev_trig and an analog core
// that samples on core_sample and returns core_data at completion ticks
//
// Overview of operation
// - four channels, own input, start, result
// - per-channel result, event, interrupt and dma
// - one shared pipeline, one issue per tick
// - result written only by own channel
// - plain differential negative is pin 0..3
// - gained differential negative is pin 4..7
// - gain code picks 1/2x up to 64x
// - single-ended any pin, either mode
// - signed single-ended uses internal ground
// - unsigned uses half reference minus offset
// - internal temp, bandgap, dac, vcc/10
// - differential negative may be pad/internal ground
// - signed internal measurement uses internal ground
// - global signed or unsigned result form
// - 12-bit default, 8-bit faster option
// - per-channel event or software start
// - optional flag on threshold compare
// - signed results sign-extended to 16 bits
// - one compare threshold for all channels
// - simultaneous starts served lowest channel first
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module adcc_top
  import adcc_pkg::*;
#(
  parameter int NEV = 8,
  parameter int NSLOT = LAT_MAX
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // event system
  input wire logic [NEV-1:0] ev_trig,
  // analog core
  output adcc_core_s core_req,
  output logic core_sample,
  input wire logic [DW-1:0] core_data,
  // per-channel requests
  output logic [NCH-1:0] ch_event,
  output logic [NCH-1:0] ch_irq,
  output logic [NCH-1:0] dma_req
);
  if (NEV < 1 || NEV > 8) begin : g_chk
    $error("adcc_top: NEV must be 1 to 8");
  end

  function automatic logic is_ch(input logic [7:0] a);
    return a[7:5] == OFS_CH_PAGE && a[1:0] == 2'b00;
  endfunction

  function automatic logic [RW-1:0] fmt_res(input logic [DW-1:0] d,
                                            input logic sgn,
                                            input logic r8);
    if (r8) begin
      return sgn ? {{8{d[7]}}, d[7:0]} : {8'h00, d[7:0]};
    end
    return sgn ? {{4{d[11]}}, d} : {4'h0, d};
  endfunction

  function automatic logic cmp_hit(input logic [RW-1:0] r,
                                   input logic [CMPW-1:0] th,
                                   input logic sgn,
                                   input adcc_cmp_e m);
    logic [RW-1:0] t;
    logic gt;
    logic lt;
    t = sgn ? {{4{th[11]}}, th} : {4'h0, th};
    gt = sgn ? ($signed(r) > $signed(t)) : (r > t);
    lt = sgn ? ($signed(r) < $signed(t)) : (r < t);
    case (m)
      CMP_ANY: return 1'b1;
      CMP_ABOVE: return gt;
      CMP_BELOW: return lt;
      default: return 1'b0;
    endcase
  endfunction

  // input routing towards the core
  function automatic adcc_core_s route(input adcc_chcfg_s c,
                                       input logic sgn,
                                       input logic r8);
    adcc_core_s q;
    q.pos_sel = {1'b0, c.poss};
    q.neg_sel = NEG_INTGND;
    q.gain_en = 1'b0;
    q.gain = c.gain;
    q.signed_m = sgn;
    q.res8 = r8;
    case (c.mode)
      MODE_DIFF, MODE_DIFFGAIN: begin
        if (c.negs >= CFG_NEG_PINS) begin
          q.neg_sel = (c.negs == CFG_NEG_PADGND) ? NEG_PADGND : NEG_INTGND;
        end else if (c.mode == MODE_DIFF) begin
          q.neg_sel = {2'b00, c.negs[1:0]};
        end else begin
          q.neg_sel = NEG_GAIN_BASE | {2'b00, c.negs[1:0]};
        end
        q.gain_en = (c.mode == MODE_DIFFGAIN);
      end
      default: begin
        if (c.mode == MODE_INTERNAL) begin
          q.pos_sel = POS_INT_BASE | {3'b000, c.poss[1:0]};
        end
        q.neg_sel = sgn ? NEG_INTGND : NEG_HALFREF;
      end
    endcase
    return q;
  endfunction

  // bus state
  logic [7:0] addr_r, addr_nxt;
  logic wr_ph_r, wr_ph_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic acc;
  logic rd_acc;

  // registers
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [CMPW-1:0] cmp_r, cmp_nxt;
  adcc_chcfg_s cfg_r [NCH];
  adcc_chcfg_s cfg_nxt [NCH];
  logic [RW-1:0] res_r [NCH];
  logic [RW-1:0] res_nxt [NCH];
  logic [NCH-1:0] flag_r, flag_nxt;
  logic [NCH-1:0] dma_r, dma_nxt;
  logic [NCH-1:0] ev_r, ev_nxt;
  logic [NCH-1:0] start_wr;
  logic [NCH-1:0] flag_clr;
  logic [NCH-1:0] rd_clr;

  // scheduler state
  logic [PDIV_W-1:0] div_r, div_nxt;
  logic [NCH-1:0] pend_r, pend_nxt;
  logic last_gain_r, last_gain_nxt;
  adcc_core_s core_r, core_nxt;
  logic samp_r, samp_nxt;
  logic [NCH-1:0] ev_hit;
  logic [NCH-1:0] issue_mask;
  logic [CHW-1:0] pick;
  logic found;
  logic tick;
  logic issue;
  logic [3:0] lat;
  logic en;
  logic sgn;
  logic r8;
  logic done;
  logic [CHW-1:0] done_ch;
  logic [RW-1:0] done_res;
  logic [7:0] ev_pad;

  assign en = ctrl_r[CTRL_EN];
  assign sgn = ctrl_r[CTRL_SIGNED];
  assign r8 = ctrl_r[CTRL_RES8];
  assign acc = hsel & hready & htrans[1];
  assign rd_acc = acc & ~hwrite;
  assign ev_pad = 8'(ev_trig);

  // zero-wait slave, read data registered in the address phase
  always_comb begin
    addr_nxt = acc ? haddr[7:0] : addr_r;
    wr_ph_nxt = acc & hwrite;
    hrdata_nxt = hrdata_r;
    rd_clr = '0;
    if (rd_acc) begin
      hrdata_nxt = RD_ZERO;
      case (haddr[7:0])
        OFS_CTRL: hrdata_nxt = ctrl_r;
        OFS_CMP: hrdata_nxt = {20'h00000, cmp_r};
        OFS_START: hrdata_nxt = {28'h0000000, pend_r};
        OFS_FLAG: hrdata_nxt = {28'h0000000, flag_r};
        default: begin
          if (is_ch(haddr[7:0]) && haddr[31:8] == 24'h000000) begin
            if (haddr[CH_RES_BIT]) begin
              hrdata_nxt = {16'h0000, res_r[haddr[4:3]]};
              rd_clr[haddr[4:3]] = 1'b1;
            end else begin
              hrdata_nxt = {12'h000, cfg_r[haddr[4:3]]};
            end
          end
        end
      endcase
    end
  end

  // software writes in the data phase
  always_comb begin
    ctrl_nxt = ctrl_r;
    cmp_nxt = cmp_r;
    cfg_nxt = cfg_r;
    start_wr = '0;
    flag_clr = '0;
    if (wr_ph_r) begin
      case (addr_r)
        OFS_CTRL: ctrl_nxt = hwdata & CTRL_MASK;
        OFS_CMP: cmp_nxt = hwdata[CMPW-1:0];
        OFS_START: start_wr = hwdata[NCH-1:0];
        OFS_FLAG: flag_clr = hwdata[NCH-1:0];
        default: begin
          if (is_ch(addr_r) && !addr_r[CH_RES_BIT]) begin
            cfg_nxt[addr_r[4:3]] = adcc_chcfg_s'(hwdata[CFG_W-1:0]);
          end
        end
      endcase
    end
  end

  // scheduler: converter clock, triggers and issue
  always_comb begin
    div_nxt = div_r + 10'h001;
    tick = 1'b0;
    if (div_r >= (PDIV_MIN << ctrl_r[CTRL_PRESC_LSB +: PRESC_W]) -
                 10'h001) begin
      div_nxt = '0;
      tick = 1'b1;
    end
    for (int c = 0; c < NCH; c++) begin
      ev_hit[c] = cfg_r[c].ev_en & ev_pad[cfg_r[c].evsel];
    end
    found = 1'b0;
    pick = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (pend_r[c]) begin
        found = 1'b1;
        pick = CHW'(c);
      end
    end
    // one issue per tick; a plain conversion right after a gained one
    // would complete on the same tick, so it waits one tick
    issue = tick & en & found &
            ~(last_gain_r & (cfg_r[pick].mode != MODE_DIFFGAIN));
    issue_mask = issue ? (NCH'(1) << pick) : '0;
    lat = LAT_BASE + ((r8 ? RES_BITS8 : RES_BITS12) >> 1) +
          ((cfg_r[pick].mode == MODE_DIFFGAIN) ? LAT_GAIN : 4'h0);
    pend_nxt = en ? ((pend_r & ~issue_mask) | start_wr | ev_hit) : '0;
    last_gain_nxt = tick ? (issue & (cfg_r[pick].mode == MODE_DIFFGAIN))
                         : last_gain_r;
    core_nxt = issue ? route(cfg_r[pick], sgn, r8) : core_r;
    samp_nxt = issue;
  end

  adcc_slot_track #(
    .NSLOT(NSLOT)
  ) u_track (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(~en),
    .tick(tick),
    .issue(issue),
    .issue_ch(pick),
    .issue_lat(lat),
    .done(done),
    .done_ch(done_ch)
  );

  // completion: result, flag, event and dma per channel
  always_comb begin
    res_nxt = res_r;
    done_res = fmt_res(core_data, sgn, r8);
    ev_nxt = '0;
    flag_nxt = flag_r & ~flag_clr;
    dma_nxt = dma_r & ~rd_clr;
    if (done) begin
      res_nxt[done_ch] = done_res;
      dma_nxt[done_ch] = 1'b1;
      if (cmp_hit(done_res, cmp_r, sgn, cfg_r[done_ch].cmpm)) begin
        flag_nxt[done_ch] = 1'b1;
        ev_nxt[done_ch] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_ph_r <= 1'b0;
      hrdata_r <= RD_ZERO;
      ctrl_r <= CTRL_RST;
      cmp_r <= CMP_RST;
      flag_r <= '0;
      dma_r <= '0;
      ev_r <= '0;
      div_r <= '0;
      pend_r <= '0;
      last_gain_r <= 1'b0;
      core_r <= '0;
      samp_r <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        cfg_r[c] <= adcc_chcfg_s'(CFG_RST);
        res_r[c] <= RES_RST;
      end
    end else begin
      addr_r <= addr_nxt;
      wr_ph_r <= wr_ph_nxt;
      hrdata_r <= hrdata_nxt;
      ctrl_r <= ctrl_nxt;
      cmp_r <= cmp_nxt;
      flag_r <= flag_nxt;
      dma_r <= dma_nxt;
      ev_r <= ev_nxt;
      div_r <= div_nxt;
      pend_r <= pend_nxt;
      last_gain_r <= last_gain_nxt;
      core_r <= core_nxt;
      samp_r <= samp_nxt;
      cfg_r <= cfg_nxt;
      res_r <= res_nxt;
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ch_irq[c] = flag_r[c] & cfg_r[c].ie;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign core_req = core_r;
  assign core_sample = samp_r;
  assign ch_event = ev_r;
  assign dma_req = dma_r;
endmodule
`default_nettype wire

/* sim/adcc_core_model.sv */
// behavioural analog core: answers each sample with a code of its routing
// assumes one sample pulse per issue and the tick period given on span
`timescale 1ns/10ps
`default_nettype none
module adcc_core_model
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // tick period in clocks
  input wire logic [PDIV_W-1:0] span,
  // converter side
  input wire adcc_core_s core_req,
  input wire logic core_sample,
  output logic [DW-1:0] core_data
);
  logic [DW-1:0] val_q[$];
  int due_q[$];
  int cyc;
  int lat;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      val_q.delete();
      due_q.delete();
      cyc = 0;
      core_data <= 12'hA5A;
    end else begin
      cyc = cyc + 1;
      if (due_q.size() > 0 && cyc >= due_q[0]) begin
        void'(val_q.pop_front());
        void'(due_q.pop_front());
      end
      if (core_sample === 1'b1) begin
        lat = 1 + (core_req.res8 ? 4 : 6) + int'(core_req.gain_en);
        val_q.push_back({core_req.pos_sel, core_req.neg_sel, core_req.gain});
        due_q.push_back(cyc + lat * int'(span) + 1);
      end
      // idle data toggles so a stale sample cannot pass
      core_data <= (val_q.size() > 0) ? val_q[0] : ~core_data;
    end
  end
endmodule
`default_nettype wire

/* sim/adcc_top_monitor.sv */
// port checker for the converter channel control
// assumes it is bound into every adcc_top instance
`timescale 1ns/10ps
`default_nettype none
module adcc_top_monitor
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // converter side
  input wire adcc_core_s core_req,
  input wire logic core_sample,
  // per-channel requests
  input wire logic [NCH-1:0] ch_event,
  input wire logic [NCH-1:0] dma_req
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_issue;
    core_sample;
  endsequence
  sequence s_gap;
    !core_sample [*3];
  endsequence
  // a tick spans at least four clocks
  a_issue_gap:
    assert property (s_issue |=> s_gap)
    else $error("core samples too close");
  a_req_steady:
    assert property ($changed(core_req) |-> core_sample)
    else $error("core request moved between issues");
  a_plain_neg:
    assert property (s_issue ##0 (!core_req.gain_en &&
      core_req.neg_sel < NEG_PADGND) |-> core_req.neg_sel < NEG_GAIN_BASE)
    else $error("plain differential negative off pins 0 to 3");
  a_gain_neg:
    assert property (core_sample && core_req.gain_en |->
      core_req.neg_sel >= NEG_GAIN_BASE && core_req.neg_sel < NEG_PADGND)
    else $error("gained negative off pins 4 to 7");
  a_int_signed:
    assert property (core_sample && core_req.signed_m &&
      core_req.pos_sel >= POS_INT_BASE |-> core_req.neg_sel == NEG_INTGND)
    else $error("signed internal input not on internal ground");
  a_int_unsigned:
    assert property (core_sample && !core_req.signed_m &&
      core_req.pos_sel >= POS_INT_BASE |-> core_req.neg_sel == NEG_HALFREF)
    else $error("unsigned internal input not on half reference");
  a_event_single:
    assert property ($onehot0(ch_event))
    else $error("two channel events at once");
  a_event_dma:
    assert property (|ch_event |-> (ch_event & ~dma_req) == 4'h0)
    else $error("channel event without its dma request");
  a_event_pulse:
    assert property (|ch_event |=> (ch_event & $past(ch_event)) == 4'h0)
    else $error("channel event longer than one clock");
endmodule
bind adcc_top adcc_top_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
  .core_req(core_req), .core_sample(core_sample), .ch_event(ch_event),
  .dma_req(dma_req));
`default_nettype wire

/* sim/tb_adcc_top.sv */
// self-checking bench for the converter channel control
// assumes the core model answers every sample with its routing code
`timescale 1ns/10ps
`default_nettype none
module tb_adcc_top
  import adcc_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] ev_trig = 8'h00;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire adcc_core_s core_req;
  wire logic core_sample;
  wire logic [DW-1:0] core_data;
  wire logic [NCH-1:0] ch_event;
  wire logic [NCH-1:0] ch_irq;
  wire logic [NCH-1:0] dma_req;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [4:0] ord[$];
  logic [31:0] rd;
  // sticky record of channel event pulses, cleared by ev_clr
  logic [3:0] ev_seen = 4'h0;
  logic ev_clr = 1'b0;

  always #2 hclk = ~hclk;

  adcc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ev_trig(ev_trig), .core_req(core_req),
    .core_sample(core_sample), .core_data(core_data), .ch_event(ch_event),
    .ch_irq(ch_irq), .dma_req(dma_req));
  adcc_core_model u_core (.hclk(hclk), .hresetn(hresetn), .span(PDIV_MIN),
    .core_req(core_req), .core_sample(core_sample), .core_data(core_data));

  always @(posedge hclk) begin
    if (core_sample === 1'b1)
      ord.push_back(core_req.pos_sel);
    ev_seen <= ev_clr ? 4'h0 : (ev_seen | ch_event);
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wait_dma(input int ch);
    int n;
    n = 0;
    while (dma_req[ch] !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk("dma_req", 32'h1, {31'h0, dma_req[ch]});
  endtask

  function automatic logic [19:0] cf(input logic [1:0] m, input logic [3:0] p,
                                     input logic [3:0] n, input logic [2:0] g);
    return {7'h00, g, n, p, m};
  endfunction

  // ctl is {res8, signed, enable}; d is the routing code the core returns
  task automatic conv(input int ch, input logic [2:0] ctl,
                      input logic [19:0] c, input logic [11:0] d);
    logic [15:0] e;
    e = ctl[2] ? {{8{ctl[1] & d[7]}}, d[7:0]} : {{4{ctl[1] & d[11]}}, d};
    wr(32'h0, {29'h0, ctl});
    wr(32'h20 + 8 * ch, {12'h0, c});
    wr(32'h8, 32'h1 << ch);
    wait_dma(ch);
    rdc(32'h24 + 8 * ch, {16'h0, e});
  endtask

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(32'h0, CTRL_RST);
    rdc(32'h4, 32'h0);
    rdc(32'hC, 32'h0);
    rdc(32'h24, 32'h0);
    wr(32'h80, 32'hFFFF_FFFF);
    rdc(32'h80, RD_ZERO);
    $display("test reset done");
    conv(0, 3'h3, cf(2'h0, 4'h9, 4'h2, 3'h0), 12'h490);
    conv(1, 3'h3, cf(2'h0, 4'h3, 4'h4, 3'h0), 12'h1C0);
    conv(2, 3'h3, cf(2'h0, 4'h3, 4'h6, 3'h0), 12'h1C8);
    for (int g = 0; g < 8; g++)
      conv(3, 3'h3, cf(2'h1, 4'hF, 4'(g % 4), 3'(g)),
           {5'h0F, 2'h1, 2'(g), 3'(g)});
    conv(0, 3'h3, cf(2'h2, 4'h5, 4'h0, 3'h0), 12'h2C8);
    conv(1, 3'h1, cf(2'h2, 4'h5, 4'h0, 3'h0), 12'h2D0);
    for (int k = 0; k < 4; k++)
      conv(k, 3'h3, cf(2'h3, 4'(k), 4'h0, 3'h0),
           {3'h4, 2'(k), 4'h9, 3'h0});
    conv(2, 3'h1, cf(2'h3, 4'h2, 4'h0, 3'h0), 12'h950);
    conv(3, 3'h5, cf(2'h2, 4'h3, 4'h0, 3'h0), 12'h1D0);
    conv(3, 3'h7, cf(2'h3, 4'h1, 4'h0, 3'h0), 12'h8C8);
    $display("test routing done");
    wr(32'h0, 32'h3);
    for (int i = 0; i < 4; i++)
      wr(32'h20 + 8 * i, {12'h0, cf(2'h2, 4'(8 + i), 4'h0, 3'h0)});
    ord.delete();
    wr(32'h8, 32'hF);
    wait_dma(3);
    for (int i = 0; i < 4; i++) begin
      chk("order", 32'(8 + i), {27'h0, ord[i]});
      rdc(32'h24 + 8 * i, {20'h0, 3'h2, 2'(i), 4'h9, 3'h0});
    end
    chk("dma_clear", 32'h0, {28'h0, dma_req});
    wr(32'h8, 32'h1);
    wait_dma(0);
    rdc(32'h2C, {20'h0, 5'h09, 4'h9, 3'h0});
    $display("test channels done");
    wr(32'hC, 32'hF);
    wr(32'h4, 32'h400);
    rdc(32'h4, 32'h400);
    wr(32'h20, {12'h0, cf(2'h2, 4'h9, 4'h0, 3'h0) | {7'h05, 13'h0}});
    wr(32'h28, {12'h0, cf(2'h2, 4'h9, 4'h0, 3'h0) | {7'h06, 13'h0}});
    ev_clr <= 1'b1;
    @(posedge hclk);
    ev_clr <= 1'b0;
    wr(32'h8, 32'h3);
    wait_dma(1);
    rdc(32'hC, 32'h1);
    chk("ch_irq", 32'h1, {28'h0, ch_irq});
    chk("ch_event", 32'h1, {28'h0, ev_seen});
    wr(32'hC, 32'h1);
    rdc(32'hC, 32'h0);
    $display("test compare done");
    wr(32'h30, {12'h0, cf(2'h2, 4'h4, 4'h0, 3'h0) | {7'h5B, 13'h0}});
    ev_trig <= 8'h10;
    @(posedge hclk);
    ev_trig <= 8'h00;
    repeat (60) @(posedge hclk);
    chk("dma_req", 32'h0, {31'h0, dma_req[2]});
    ev_trig <= 8'h20;
    @(posedge hclk);
    ev_trig <= 8'h00;
    wait_dma(2);
    rdc(32'h34, 32'h248);
    chk("ch_event", 32'h1, {28'h0, ev_seen});
    rdc(32'hC, 32'h0);
    $display("test events done");
    finish_test();
  end
endmodule
`default_nettype wire
